// ==== pkg/tmr_pkg.sv ====
// Operation
// - Sixteen-bit count held as low and high byte, both read/write.
// - Counting advances only while enable bit 0 is set.
// - Bit 1 selects external pin clock (1) or internal Fosc/4 (0).
// - Internal: one step per instruction cycle; external: per rising edge.
// - External rising edges are ignored until one falling edge is seen.
// - Bits 5-4 prescale the input by 1, 2, 4 or 8.
// - Bit 2 set bypasses external synchronisation; ignored when internal.
// - Oscillator enable bit 3 forces both oscillator pins to inputs.
// - Enabled low-power oscillator keeps running during sleep.
// - Count wraps from FFFF to 0000; that wrap is overflow.
// - Overflow sets flag bit 0, held until software clears it.
// - Overflow interrupt raised only when enable bit 0 is set.
// - Compare mode 1011 special event trigger resets the count.
// - Trigger reset never sets the overflow flag.
// - A count write in the trigger cycle wins over the reset.
// - In trigger mode the compare value acts as the period.
package tmr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_CNT_L = 8'h0e;
  localparam logic [7:0] IDX_CNT_H = 8'h0f;
  localparam logic [7:0] IDX_CTRL  = 8'h10;
  localparam logic [7:0] IDX_CMP_L = 8'h15;
  localparam logic [7:0] IDX_CMP_H = 8'h16;
  localparam logic [7:0] IDX_MODE  = 8'h17;
  localparam logic [7:0] IDX_IEN   = 8'h8c;

  // Flag and enable bit positions
  localparam int BIT_OVF = 0;
  localparam int BIT_CMP = 2;
  localparam logic [7:0] IRQ_MASK = 8'h05;

  // Reset values
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [3:0]  MODE_SPECIAL = 4'hb;

  // Instruction cycle is Fosc/4
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);

  // Counter control register layout
  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] prescale;
    logic       osc_en;
    logic       sync_bypass;
    logic       clk_src;
    logic       enable;
  } tmr_ctrl_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } tmr_bus_st_t;

endpackage

// ==== rtl/tmr_counter.sv ====
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tmr_counter (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Pins and port state
  input  wire logic        i_ext_clk,
  input  wire logic [1:0]  i_port_b_direction,
  input  wire logic        i_sleep,
  output logic      [1:0]  o_osc_pin_oe,
  output logic             o_aux_osc_run,
  // Interrupt
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////
  // Bus slave
  tmr_pkg::tmr_bus_st_t st_r, st_nxt;
  logic        wreq_r, wreq_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [7:0]  idx;
  logic        req;
  logic        acc;
  logic        wr;
  logic [7:0]  wd;
  assign idx = i_avs_address[9:2];
  assign req = i_avs_read | i_avs_write;
  // Access completes in the cycle waitrequest is low
  assign acc = req & (st_r == tmr_pkg::BUS_ACK);
  assign wr  = acc & i_avs_write & i_avs_byteenable[0];
  assign wd  = i_avs_writedata[7:0];
  tmr_pkg::tmr_ctrl_t ctrl_r, ctrl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] cmp_r, cmp_nxt;
  logic [3:0]  mode_r, mode_nxt;
  logic [7:0]  flg_r, flg_nxt;
  logic [7:0]  ien_r, ien_nxt;

  // One wait state: the read word is latched while waiting
  always_comb begin
    st_nxt   = st_r;
    wreq_nxt = 1'b1;
    rdat_nxt = rdat_r;
    case (st_r)
      tmr_pkg::BUS_IDLE: begin
        if (req) begin
          st_nxt   = tmr_pkg::BUS_ACK;
          wreq_nxt = 1'b0;
          rdat_nxt = 32'h0000_0000;
          case (idx)
            tmr_pkg::IDX_FLAGS: rdat_nxt[7:0] = flg_r;
            tmr_pkg::IDX_CNT_L: rdat_nxt[7:0] = cnt_r[7:0];
            tmr_pkg::IDX_CNT_H: rdat_nxt[7:0] = cnt_r[15:8];
            tmr_pkg::IDX_CTRL:  rdat_nxt[7:0] = ctrl_r;
            tmr_pkg::IDX_CMP_L: rdat_nxt[7:0] = cmp_r[7:0];
            tmr_pkg::IDX_CMP_H: rdat_nxt[7:0] = cmp_r[15:8];
            tmr_pkg::IDX_MODE:  rdat_nxt[3:0] = mode_r;
            tmr_pkg::IDX_IEN:   rdat_nxt[7:0] = ien_r;
            default:            rdat_nxt = 32'h0000_0000;
          endcase
        end
      end
      tmr_pkg::BUS_ACK: st_nxt = tmr_pkg::BUS_IDLE;
      default:          st_nxt = tmr_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r   <= tmr_pkg::BUS_IDLE;
      wreq_r <= 1'b1;
      rdat_r <= 32'h0000_0000;
    end else begin
      st_r   <= st_nxt;
      wreq_r <= wreq_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign o_avs_waitrequest = wreq_r;
  assign o_avs_readdata    = rdat_r;

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser and instruction-cycle divider
  logic       ext_s1_r, ext_s2_r, ext_q_r;
  logic [1:0] div_r, div_nxt;
  logic       cyc_en;
  logic       ext_rise;
  logic       ext_fall;
  // Two flops before any logic looks at the pin
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_q_r  <= 1'b0;
    end else begin
      ext_s1_r <= i_ext_clk;
      ext_s2_r <= ext_s1_r;
      ext_q_r  <= ext_s2_r;
    end
  end

  assign ext_rise = ext_s2_r & ~ext_q_r;
  assign ext_fall = ~ext_s2_r & ext_q_r;

  // Divider runs always; sleep stops the instruction clock
  always_comb begin
    div_nxt = div_r + 2'h1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign cyc_en = (div_r == tmr_pkg::DIV_LAST) & ~i_sleep;

  ////////////////////////////////////////////////////////////////////
  // Edge qualifying, prescaler and sync path
  logic       seen_r, seen_nxt;
  logic [2:0] ps_r, ps_nxt;
  logic       pend_r, pend_nxt;
  logic [2:0] ps_last;
  logic       src_edge;
  logic       pre_tick;
  logic       sync_md;
  logic       inc;

  assign ps_last = 3'((4'h1 << ctrl_r.prescale) - 4'h1);
  // Sync applies only to the external source
  assign sync_md = ctrl_r.clk_src & ~ctrl_r.sync_bypass;

  always_comb begin
    seen_nxt = seen_r;
    ps_nxt   = ps_r;
    pend_nxt = pend_r;
    src_edge = 1'b0;
    pre_tick = 1'b0;
    inc      = 1'b0;
    if (!ctrl_r.clk_src) begin
      seen_nxt = 1'b0;
    end else if (ext_fall) begin
      seen_nxt = 1'b1;
    end
    // Pick instruction cycle or pin edge
    if (ctrl_r.clk_src) begin
      src_edge = ext_rise & seen_r;
    end else begin
      src_edge = cyc_en;
    end
    if (ctrl_r.enable) begin
      if (src_edge) begin
        if (ps_r >= ps_last) begin
          ps_nxt   = 3'h0;
          pre_tick = 1'b1;
        end else begin
          ps_nxt = ps_r + 3'h1;
        end
      end
      // Synced edges wait for an instruction cycle
      if (sync_md) begin
        inc      = (pend_r | pre_tick) & cyc_en;
        pend_nxt = (pend_r | pre_tick) & ~cyc_en;
      end else begin
        inc      = pre_tick;
        pend_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_r <= 1'b0;
      ps_r   <= 3'h0;
      pend_r <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
      ps_r   <= ps_nxt;
      pend_r <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Count, compare trigger and control registers
  logic match_q_r, match_q_nxt;
  logic match;
  logic trig;
  logic ovf;
  logic wr_cnt;

  assign match  = (cnt_r == cmp_r);
  // Special event fires once per match
  assign trig   = (mode_r == tmr_pkg::MODE_SPECIAL) & match
                & ~match_q_r;
  assign wr_cnt = wr & ((idx == tmr_pkg::IDX_CNT_L) |
                        (idx == tmr_pkg::IDX_CNT_H));

  always_comb begin
    cnt_nxt     = cnt_r;
    ctrl_nxt    = ctrl_r;
    cmp_nxt     = cmp_r;
    mode_nxt    = mode_r;
    match_q_nxt = match & (mode_r == tmr_pkg::MODE_SPECIAL);
    ovf         = 1'b0;
    if (wr_cnt) begin
      if (idx == tmr_pkg::IDX_CNT_L) begin
        cnt_nxt[7:0] = wd;
      end else begin
        cnt_nxt[15:8] = wd;
      end
    end else if (trig) begin
      cnt_nxt = tmr_pkg::RST_CNT;
    // Wrap FFFF to 0000 is overflow
    end else if (inc) begin
      cnt_nxt = cnt_r + 16'h0001;
      ovf     = (cnt_r == tmr_pkg::CNT_MAX);
    end
    if (wr) begin
      case (idx)
        tmr_pkg::IDX_CTRL:  ctrl_nxt = {2'b00, wd[5:0]};
        tmr_pkg::IDX_CMP_L: cmp_nxt[7:0] = wd;
        tmr_pkg::IDX_CMP_H: cmp_nxt[15:8] = wd;
        tmr_pkg::IDX_MODE:  mode_nxt = wd[3:0];
        default:            mode_nxt = mode_r;
      endcase
    end
  end

  // Count is undefined at power-up on the part; cleared here
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r     <= tmr_pkg::RST_CNT;
      ctrl_r    <= tmr_pkg::RST_CTRL;
      cmp_r     <= tmr_pkg::RST_CNT;
      mode_r    <= 4'h0;
      match_q_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      ctrl_r    <= ctrl_nxt;
      cmp_r     <= cmp_nxt;
      mode_r    <= mode_nxt;
      match_q_r <= match_q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flags, enables and interrupt
  logic irq_r, irq_nxt;
  logic wr_flg;

  assign wr_flg = wr & (idx == tmr_pkg::IDX_FLAGS);

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    flg_nxt = flg_r;
    ien_nxt = ien_r;
    if (wr_flg) begin
      flg_nxt = flg_r & ~(wd & tmr_pkg::IRQ_MASK);
    end
    if (ovf) begin
      flg_nxt[tmr_pkg::BIT_OVF] = 1'b1;
    end
    if (trig) begin
      flg_nxt[tmr_pkg::BIT_CMP] = 1'b1;
    end
    if (wr & (idx == tmr_pkg::IDX_IEN)) begin
      ien_nxt = wd & tmr_pkg::IRQ_MASK;
    end
    irq_nxt = |(flg_r & ien_r);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flg_r <= 8'h00;
      ien_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      flg_r <= flg_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_irq = irq_r;

  ////////////////////////////////////////////////////////////////////
  // Oscillator pins
  logic [1:0] oe_r, oe_nxt;
  logic       run_r, run_nxt;

  always_comb begin
    oe_nxt  = ctrl_r.osc_en ? 2'b00 : ~i_port_b_direction;
    run_nxt = ctrl_r.osc_en;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_r  <= 2'b00;
      run_r <= 1'b0;
    end else begin
      oe_r  <= oe_nxt;
      run_r <= run_nxt;
    end
  end

  assign o_osc_pin_oe  = oe_r;
  assign o_aux_osc_run = run_r;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_top_step;
    inc && !wr_cnt && !trig && cnt_r == tmr_pkg::CNT_MAX;
  endsequence
  sequence s_wrapped;
    cnt_r == 16'h0000 && flg_r[tmr_pkg::BIT_OVF];
  endsequence
  property p_wr_low;
    wr && idx == tmr_pkg::IDX_CNT_L |=> cnt_r[7:0] == $past(wd);
  endproperty
  a_wr_low: assert property (p_wr_low)
    else $error("low byte write lost");
  property p_hold;
    !ctrl_r.enable && !wr_cnt && !trig
      |=> $stable(cnt_r) && $stable(ps_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while disabled");
  property p_timer_rate;
    inc && !ctrl_r.clk_src |-> cyc_en ##1 !cyc_en [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate)
    else $error("timer step off instruction cycle");
  property p_first_fall;
    ctrl_r.clk_src && !seen_r |-> !src_edge;
  endproperty
  a_first_fall: assert property (p_first_fall)
    else $error("edge counted before first fall");
  // A smaller prescale setting lets a carried count tick at once
  property p_presc;
    pre_tick |-> (ps_r >= ps_last && src_edge && ctrl_r.enable)
      ##1 ps_r == 3'h0;
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler tick at wrong count");
  property p_sync;
    inc && sync_md |-> cyc_en;
  endproperty
  a_sync: assert property (p_sync)
    else $error("synced step off instruction cycle");
  property p_pin_oe;
    ctrl_r.osc_en |=> o_osc_pin_oe == 2'b00;
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("oscillator pin driven");
  property p_wrap;
    s_top_step |=> s_wrapped;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not flag overflow");
  property p_trig;
    trig && !wr_cnt && !ovf && !flg_r[tmr_pkg::BIT_OVF]
      && !wr_flg |=> cnt_r == 16'h0000 && !flg_r[tmr_pkg::BIT_OVF];
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger reset failed or set overflow");
  property p_irq;
    flg_r[tmr_pkg::BIT_OVF] && !ien_r[tmr_pkg::BIT_OVF]
      && !flg_r[tmr_pkg::BIT_CMP] |=> !o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("masked overflow raised irq");
endmodule

// ==== test/sixteen_bit_timer_counter_tb.sv ====
`timescale 1ns/1ps
module sixteen_bit_timer_counter_tb;
  logic        mclk;
  logic        rst_n;
  logic [9:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wreq;
  logic        ext_clk;
  logic [1:0]  dir;
  logic        sleep;
  logic [1:0]  oe;
  logic        osc_run;
  logic        irq;
  logic [7:0]  rv;
  int          n_fail;
  int          n_checks;

  tmr_counter i_dut (
    .i_mclk             (mclk),
    .i_rst_n            (rst_n),
    .i_avs_address      (addr),
    .i_avs_read         (rd),
    .i_avs_write        (wr),
    .i_avs_writedata    (wdata),
    .i_avs_byteenable   (be),
    .o_avs_readdata     (rdata),
    .o_avs_waitrequest  (wreq),
    .i_ext_clk          (ext_clk),
    .i_port_b_direction (dir),
    .i_sleep            (sleep),
    .o_osc_pin_oe       (oe),
    .o_aux_osc_run      (osc_run),
    .o_irq              (irq)
  );
  // Odd half period keeps every other pin edge off the clock edges; the rest land on them
  tmr_ext_src #(.HALF_NS(41)) i_src (.o_clk(ext_clk));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks; range form covers unknown phase of divider
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                         input logic [7:0] hi, input string what);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h", $time, what, got);
    end
  endtask

  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic [7:0] idx, input logic we,
                     input logic [7:0] d);
    @(posedge mclk);
    addr  <= {idx, 2'b00};
    wdata <= {24'h0, d};
    rd    <= ~we;
    wr    <= we;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    rv = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input string what);
    bus(idx, 1'b0, 8'h00);
    chk(rv, exp, what);
  endtask
  // Count is written only while stopped, so the bytes cannot tear
  task automatic set_cnt(input logic [15:0] v);
    wr_reg(tmr_pkg::IDX_CTRL, 8'h00);
    wr_reg(tmr_pkg::IDX_CNT_L, v[7:0]);
    wr_reg(tmr_pkg::IDX_CNT_H, v[15:8]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(tmr_pkg::IDX_CTRL, tmr_pkg::RST_CTRL, "ctrl reset");
    rd_chk(tmr_pkg::IDX_FLAGS, 8'h00, "flags reset");
    rd_chk(8'h20, 8'h00, "unmapped read");
    chk({7'h0, irq}, 8'h00, "irq reset");
    $display("test reset done");
  endtask

  task automatic t_rw();
    wr_reg(tmr_pkg::IDX_CTRL, 8'hf0);
    rd_chk(tmr_pkg::IDX_CTRL, 8'h30, "ctrl upper bits");
    wr_reg(tmr_pkg::IDX_CNT_L, 8'ha5);
    wr_reg(tmr_pkg::IDX_CNT_H, 8'h3c);
    // A write without byte lane 0 must be dropped
    be <= 4'he;
    wr_reg(tmr_pkg::IDX_CNT_L, 8'h11);
    be <= 4'hf;
    repeat (64) @(posedge mclk);
    rd_chk(tmr_pkg::IDX_CNT_L, 8'ha5, "low held");
    rd_chk(tmr_pkg::IDX_CNT_H, 8'h3c, "high held");
    $display("test rw done");
  endtask

  // About 256 mclk enabled = 64 instruction cycles, divided by prescale
  task automatic t_presc();
    logic [7:0] e;
    for (int p = 0; p < 4; p++) begin
      e = 8'(64 >> p);
      set_cnt(16'h0000);
      wr_reg(tmr_pkg::IDX_CTRL, {2'b00, 2'(p), 4'b0001});
      repeat (254) @(posedge mclk);
      wr_reg(tmr_pkg::IDX_CTRL, 8'h00);
      bus(tmr_pkg::IDX_CNT_L, 1'b0, 8'h00);
      chk_rng(rv, e - 8'h01, e + 8'h01, "prescaled count");
    end
    $display("test prescale done");
  endtask

  task automatic t_ovf();
    set_cnt(16'hfffd);
    wr_reg(tmr_pkg::IDX_IEN, 8'h00);
    wr_reg(tmr_pkg::IDX_CTRL, 8'h01);
    repeat (40) @(posedge mclk);
    rd_chk(tmr_pkg::IDX_FLAGS, 8'h01, "overflow flag");
    chk({7'h0, irq}, 8'h00, "irq masked");
    wr_reg(tmr_pkg::IDX_IEN, 8'h01);
    repeat (2) @(posedge mclk);
    chk({7'h0, irq}, 8'h01, "irq enabled");
    wr_reg(tmr_pkg::IDX_CTRL, 8'h00);
    rd_chk(tmr_pkg::IDX_CNT_H, 8'h00, "wrapped high");
    wr_reg(tmr_pkg::IDX_FLAGS, 8'h01);
    repeat (2) @(posedge mclk);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    $display("test overflow done");
  endtask

  // Compare value 5 acts as the period: count never passes it
  task automatic t_trig();
    set_cnt(16'h0000);
    wr_reg(tmr_pkg::IDX_CMP_L, 8'h05);
    wr_reg(tmr_pkg::IDX_CMP_H, 8'h00);
    wr_reg(tmr_pkg::IDX_MODE, {4'h0, tmr_pkg::MODE_SPECIAL});
    wr_reg(tmr_pkg::IDX_CTRL, 8'h01);
    repeat (200) @(posedge mclk);
    wr_reg(tmr_pkg::IDX_CTRL, 8'h00);
    bus(tmr_pkg::IDX_CNT_L, 1'b0, 8'h00);
    chk_rng(rv, 8'h00, 8'h05, "period bound");
    rd_chk(tmr_pkg::IDX_FLAGS, 8'h04, "no overflow flag");
    rd_chk(tmr_pkg::IDX_CNT_H, 8'h00, "reset high");
    wr_reg(tmr_pkg::IDX_FLAGS, 8'h05);
    wr_reg(tmr_pkg::IDX_MODE, 8'h00);
    $display("test trigger done");
  endtask

  task automatic t_pins();
    repeat (2) @(posedge mclk);
    chk({6'h0, oe}, 8'h03, "oe follows direction");
    wr_reg(tmr_pkg::IDX_CTRL, 8'h08);
    repeat (2) @(posedge mclk);
    chk({6'h0, oe}, 8'h00, "oe forced off");
    chk({7'h0, osc_run}, 8'h01, "osc running");
    $display("test pins done");
  endtask

  // Synchronised external counting, then bypass path during sleep
  task automatic t_ext();
    set_cnt(16'h0000);
    wr_reg(tmr_pkg::IDX_CTRL, 8'h0b);
    repeat (100) @(posedge mclk);
    i_src.rise();
    i_src.pulse(4);
    repeat (20) @(posedge mclk);
    rd_chk(tmr_pkg::IDX_CNT_L, 8'h04, "first rise ignored");
    wr_reg(tmr_pkg::IDX_CTRL, 8'h0f);
    sleep <= 1'b1;
    i_src.pulse(3);
    repeat (20) @(posedge mclk);
    rd_chk(tmr_pkg::IDX_CNT_L, 8'h07, "bypass in sleep");
    chk({7'h0, osc_run}, 8'h01, "osc runs in sleep");
    sleep <= 1'b0;
    $display("test external done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_n    = 1'b0;
    rd       = 1'b0;
    wr       = 1'b0;
    addr     = 10'h000;
    wdata    = 32'h0;
    be       = 4'hf;
    dir      = 2'b00;
    sleep    = 1'b0;
    n_fail   = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_rw();
    t_presc();
    t_ovf();
    t_trig();
    t_pins();
    t_ext();
    results();
  end

  // Whole run needs well under 5000 cycles; this is several times that
  initial begin
    #100000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
endmodule

// ==== test/tmr_ext_src.sv ====
`timescale 1ns/1ps
// Stand-in for whatever drives the external clock pin.
// The pin rests high after a burst, so each pulse opens with a fall.
module tmr_ext_src #(
  parameter int HALF_NS = 40
) (
  output logic o_clk
);
  // Pin starts low so the lone rising edge before the arming fall can be exercised
  initial o_clk = 1'b0;
  // Lone rising edge, used before any falling edge was seen
  task automatic rise();
    #(HALF_NS) o_clk = 1'b1;
  endtask
  // Full pulses; half period spans more than one instruction cycle
  task automatic pulse(input int n);
    repeat (n) begin
      #(HALF_NS) o_clk = 1'b0;
      #(HALF_NS) o_clk = 1'b1;
    end
  endtask
endmodule
